// File: core/pte_defs.svh
`ifndef PTE_DEFS_SVH
`define PTE_DEFS_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses on the APB bus)
// ----------------------------------------------------------------------
`define PTE_OFF_CFG 8'h00
`define PTE_OFF_THRESH 8'h04
`define PTE_OFF_STATUS 8'h08

// Per-port configuration field positions inside one byte lane of CFG.
`define PTE_CFG_LANE 8
`define PTE_CFG_CLASS_EN 0
`define PTE_CFG_DEF_PRIO 1
`define PTE_CFG_INSERT 2
`define PTE_CFG_REMOVE 3
`define PTE_CFG_SPLIT 4
`define PTE_CFG_MASK 32'h001F1F1F

// Reset value of the priority threshold.
`define PTE_THRESH_RST 3'h4

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define PTE_IDX_TPID_HI 5'h0C
`define PTE_IDX_TPID_LO 5'h0D
`define PTE_IDX_TCI_HI 5'h0E
`define PTE_IDX_TCI_LO 5'h0F
`define PTE_IDX_SAT 5'h10
`define PTE_TPID_HI 8'h81
`define PTE_TPID_LO 8'h00
`define PTE_INS_PRIO_HI 3'h7
`define PTE_INS_PRIO_LO 3'h0
`define PTE_TAG_LEN 3'h4

// Reorder buffer that absorbs the four inserted bytes.
`define PTE_FIFO_DEPTH 8
`define PTE_FIFO_AW 3

`endif

// File: core/pte_pkg.sv
package pte_pkg;

   typedef logic [7:0] pte_byte_t;
   typedef logic [2:0] pte_prio_t;

   // One buffered byte with the per-frame marks that travel beside it.
   typedef struct packed {
      logic high_q;
      logic cls;
      logic last;
      logic ins;
      pte_byte_t data;
   } pte_entry_s;

endpackage : pte_pkg

// File: core/pte_top.sv
// Operation
// - Each port has its own tag classification enable.
// - Untagged or disabled: use port default priority.
// - Classification enable defaults off, strap low.
// - Insert enabled: add tag to untagged frames.
// - Inserted priority 000 if default low, else 111.
// - Insert strap high enables; low passes unmodified.
// - Remove enabled strips tag; default unmodified.
// - Insert and remove both set: unmodified.
// - Tag priority >= threshold goes high; threshold 100.
`timescale 1ns/10ps
`include "pte_defs.svh"

module pte_port (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cfg_class_en,
   input wire logic cfg_default_high,
   input wire logic cfg_insert,
   input wire logic cfg_remove,
   input wire logic cfg_split,
   input wire pte_pkg::pte_prio_t threshold,
   input wire logic rx_valid,
   input wire pte_pkg::pte_byte_t rx_data,
   input wire logic rx_last,
   output logic tx_valid,
   output pte_pkg::pte_byte_t tx_data,
   output logic tx_last,
   output logic tx_class_high,
   output logic tx_high_queue,
   output logic overflow
);
   import pte_pkg::*;

   // ----------------------------------------------------------------------
   // Receive side: byte index, one-byte look-behind and tag detection
   // ----------------------------------------------------------------------
   logic [4:0] idx_reg;
   logic [4:0] idx_next;
   logic s1_valid_reg;
   pte_byte_t s1_data_reg;
   logic s1_last_reg;
   logic [4:0] s1_idx_reg;
   logic s1_drop_reg;
   logic tag_reg;
   logic tag_next;
   pte_prio_t prio_reg;

   wire ins_only = cfg_insert & ~cfg_remove;
   wire rm_only = cfg_remove & ~cfg_insert;
   wire at_tci = rx_valid && idx_reg == `PTE_IDX_TPID_LO && s1_valid_reg &&
      s1_idx_reg == `PTE_IDX_TPID_HI;
   wire tagged_now = at_tci && s1_data_reg == `PTE_TPID_HI && rx_data == `PTE_TPID_LO;
   wire in_tag_tail = tag_reg &&
      (idx_reg == `PTE_IDX_TCI_HI || idx_reg == `PTE_IDX_TCI_LO);
   // A byte that ends the frame is never dropped, so a truncated frame still ends.
   wire drop_in = rx_valid & ~rx_last & rm_only & (tagged_now | in_tag_tail);
   wire drop_s1 = s1_drop_reg | (tagged_now & rm_only);
   wire mark_ins = at_tci & ~tagged_now & ins_only;
   wire prio_take = rx_valid && tag_reg && idx_reg == `PTE_IDX_TCI_HI;
   wire tag_high = prio_reg >= threshold;
   wire frame_high = (cfg_class_en & tag_reg) ? tag_high : cfg_default_high;

   // Index saturates past the tag so long frames need no wide counter.
   always_comb begin
      idx_next = idx_reg;
      if (rx_valid) begin
         if (rx_last) begin
            idx_next = 5'h00;
         end else if (idx_reg != `PTE_IDX_SAT) begin
            idx_next = idx_reg + 5'h01;
         end
      end
   end

   // Tag flag lives from byte 13 to the first byte of the next frame.
   always_comb begin
      tag_next = tag_reg;
      if (tagged_now) begin
         tag_next = 1'b1;
      end else if (rx_valid && idx_reg == 5'h00) begin
         tag_next = 1'b0;
      end
   end

   // The look-behind stage delays every byte by one cycle so byte 12 can be
   // judged once byte 13 arrives.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         idx_reg <= 5'h00;
         s1_valid_reg <= 1'b0;
         s1_data_reg <= 8'h00;
         s1_last_reg <= 1'b0;
         s1_idx_reg <= 5'h00;
         s1_drop_reg <= 1'b0;
         tag_reg <= 1'b0;
         prio_reg <= 3'h0;
      end else begin
         idx_reg <= idx_next;
         s1_valid_reg <= rx_valid;
         s1_data_reg <= rx_data;
         s1_last_reg <= rx_last;
         s1_idx_reg <= idx_reg;
         s1_drop_reg <= drop_in;
         tag_reg <= tag_next;
         if (prio_take) begin
            prio_reg <= rx_data[7:5];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Reorder buffer
   // ----------------------------------------------------------------------
   pte_entry_s fifo_mem [0:`PTE_FIFO_DEPTH-1];
   logic [`PTE_FIFO_AW:0] wr_ptr_reg;
   logic [`PTE_FIFO_AW:0] rd_ptr_reg;
   logic [2:0] tag_cnt_reg;
   pte_entry_s wr_entry;
   pte_byte_t tag_byte;

   wire fifo_empty = wr_ptr_reg == rd_ptr_reg;
   wire fifo_full = wr_ptr_reg ==
      {~rd_ptr_reg[`PTE_FIFO_AW], rd_ptr_reg[`PTE_FIFO_AW-1:0]};
   wire wr_en = s1_valid_reg & ~drop_s1;
   wire push = wr_en & ~fifo_full;
   wire pte_entry_s head = fifo_mem[rd_ptr_reg[`PTE_FIFO_AW-1:0]];
   wire tag_phase = ~fifo_empty & head.ins & (tag_cnt_reg != `PTE_TAG_LEN);
   wire pop = ~fifo_empty & ~tag_phase;
   wire pte_prio_t ins_prio = cfg_default_high ? `PTE_INS_PRIO_HI : `PTE_INS_PRIO_LO;

   // Class and queue marks only matter on the last byte of a frame.
   always_comb begin
      wr_entry.data = s1_data_reg;
      wr_entry.last = s1_last_reg;
      wr_entry.ins = mark_ins;
      wr_entry.cls = frame_high;
      wr_entry.high_q = cfg_split & frame_high;
   end

   // Inserted tag: type word, then priority with CFI and VLAN id zero.
   always_comb begin
      unique case (tag_cnt_reg)
         3'h0: tag_byte = `PTE_TPID_HI;
         3'h1: tag_byte = `PTE_TPID_LO;
         3'h2: tag_byte = {ins_prio, 5'h00};
         default: tag_byte = 8'h00;
      endcase
   end

   // The buffer has no reset on its storage; pointers define what is valid.
   always_ff @(posedge ref_clk) begin
      if (push) begin
         fifo_mem[wr_ptr_reg[`PTE_FIFO_AW-1:0]] <= wr_entry;
      end
   end

   // ----------------------------------------------------------------------
   // Transmit side
   // ----------------------------------------------------------------------
   // The tag is emitted ahead of byte 12 while the buffer soaks up the
   // bytes that keep arriving; the slack is paid back in the frame gap.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         tag_cnt_reg <= 3'h0;
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
         tx_last <= 1'b0;
         tx_class_high <= 1'b0;
         tx_high_queue <= 1'b0;
         overflow <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 4'h1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 4'h1;
            tag_cnt_reg <= 3'h0;
         end else if (tag_phase) begin
            tag_cnt_reg <= tag_cnt_reg + 3'h1;
         end
         tx_valid <= ~fifo_empty;
         tx_data <= tag_phase ? tag_byte : head.data;
         tx_last <= pop & head.last;
         tx_class_high <= pop & head.last & head.cls;
         tx_high_queue <= pop & head.last & head.high_q;
         overflow <= wr_en & fifo_full;
      end
   end

endmodule : pte_port

module pte_top (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] port_tag_class_enable,
   input wire logic [2:0] port_default_priority,
   input wire logic [2:0] port_tag_insert_enable,
   input wire logic [2:0] port_tag_remove_enable,
   input wire logic [2:0] port_split_txq_select,
   input wire logic [2:0] rx_valid,
   input wire pte_pkg::pte_byte_t [2:0] rx_data,
   input wire logic [2:0] rx_last,
   output logic [2:0] tx_valid,
   output pte_pkg::pte_byte_t [2:0] tx_data,
   output logic [2:0] tx_last,
   output logic [2:0] tx_class_high,
   output logic [2:0] tx_high_queue
);
   import pte_pkg::*;

   // ----------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------
   logic [31:0] cfg_reg;
   logic [31:0] cfg_next;
   pte_prio_t thresh_reg;
   logic [2:0] ovf_reg;
   logic [2:0] ovf_next;
   logic [2:0] ovf_pulse;
   logic [31:0] strap_word;
   logic [31:0] rd_mux;

   wire sel_cfg = paddr == `PTE_OFF_CFG;
   wire sel_thresh = paddr == `PTE_OFF_THRESH;
   wire sel_status = paddr == `PTE_OFF_STATUS;
   wire mapped = sel_cfg | sel_thresh | sel_status;
   wire access = psel & penable;
   wire wr_ok = access & pwrite & mapped;
   wire rd_setup = psel & ~penable & ~pwrite;

   // Every access completes in one access cycle, so ready is simply high.
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;

   assign rd_mux = sel_cfg ? cfg_reg :
      sel_thresh ? {29'h0, thresh_reg} :
      sel_status ? {29'h0, ovf_reg} : 32'h0;
   assign cfg_next = pwdata & `PTE_CFG_MASK;

   // Hardware-set overflow wins over a write-one-to-clear in the same cycle.
   assign ovf_next = (ovf_reg & ~((wr_ok & sel_status) ? pwdata[2:0] : 3'h0)) | ovf_pulse;

   // ----------------------------------------------------------------------
   // Strap capture and registers
   // ----------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_strap
         assign strap_word[gi*`PTE_CFG_LANE +: `PTE_CFG_LANE] = {3'h0,
            port_split_txq_select[gi], port_tag_remove_enable[gi],
            port_tag_insert_enable[gi], port_default_priority[gi],
            port_tag_class_enable[gi]};
      end
   endgenerate
   assign strap_word[31:24] = 8'h00;

   // Straps are held as long as reset is asserted; software may later
   // override them, which a strapped-only design cannot do.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cfg_reg <= strap_word;
         thresh_reg <= `PTE_THRESH_RST;
         ovf_reg <= 3'h0;
         prdata <= 32'h0;
      end else begin
         if (wr_ok & sel_cfg) begin
            cfg_reg <= cfg_next;
         end
         if (wr_ok & sel_thresh) begin
            thresh_reg <= pwdata[2:0];
         end
         ovf_reg <= ovf_next;
         if (rd_setup) begin
            prdata <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Per-port datapaths
   // ----------------------------------------------------------------------
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_port
         pte_port u_port (
            .ref_clk(ref_clk),
            .rst(rst),
            .cfg_class_en(cfg_reg[gi*`PTE_CFG_LANE + `PTE_CFG_CLASS_EN]),
            .cfg_default_high(cfg_reg[gi*`PTE_CFG_LANE + `PTE_CFG_DEF_PRIO]),
            .cfg_insert(cfg_reg[gi*`PTE_CFG_LANE + `PTE_CFG_INSERT]),
            .cfg_remove(cfg_reg[gi*`PTE_CFG_LANE + `PTE_CFG_REMOVE]),
            .cfg_split(cfg_reg[gi*`PTE_CFG_LANE + `PTE_CFG_SPLIT]),
            .threshold(thresh_reg),
            .rx_valid(rx_valid[gi]),
            .rx_data(rx_data[gi]),
            .rx_last(rx_last[gi]),
            .tx_valid(tx_valid[gi]),
            .tx_data(tx_data[gi]),
            .tx_last(tx_last[gi]),
            .tx_class_high(tx_class_high[gi]),
            .tx_high_queue(tx_high_queue[gi]),
            .overflow(ovf_pulse[gi])
         );
      end
   endgenerate

endmodule : pte_top

// File: verification/pte_chk.sv
`timescale 1ns/10ps
// ----------------------------------------
// Port and bus timing checks
// ----------------------------------------
module pte_chk (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [2:0] port_split_txq_select,
   input wire logic [2:0] tx_valid,
   input wire logic [2:0] tx_last,
   input wire logic [2:0] tx_class_high,
   input wire logic [2:0] tx_high_queue
);
   wire logic mapped;
   wire logic access;
   // Decode of the three word addresses and of the access phase.
   assign mapped = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08;
   assign access = psel && penable;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_ready_access: assert property (access |-> pready)
      else $error("pready low in access phase");
   a_err_unmapped: assert property (access && !mapped |-> pslverr)
      else $error("no error for unmapped address");
   a_ok_mapped: assert property (access && mapped |-> !pslverr)
      else $error("error on mapped address");
   a_err_setup: assert property (!penable |-> !pslverr)
      else $error("error outside access phase");
   a_class_end: assert property ((tx_class_high & ~tx_last) == 3'h0)
      else $error("class flag away from last byte");
   a_queue_split: assert property (|tx_last |->
      tx_high_queue == (tx_class_high & port_split_txq_select))
      else $error("queue select wrong");
   a_queue_pulse: assert property ((tx_high_queue & ~tx_last) == 3'h0)
      else $error("queue flag away from last byte");
   a_last_valid: assert property ((tx_last & ~tx_valid) == 3'h0)
      else $error("last without valid byte");
   a_last_single: assert property (tx_last[0] |=> !tx_last[0])
      else $error("last held two cycles");
   // Reset itself is the cause here, so this one is not disabled by it. Two reset edges
   // are needed: before the first one the outputs are still unknown.
   a_reset_quiet: assert property (disable iff (1'b0) rst ##1 rst |=>
      $stable(tx_valid) && tx_valid == 3'h0)
      else $error("output active after reset");
endmodule : pte_chk

bind pte_top pte_chk u_chk (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .port_split_txq_select(port_split_txq_select), .tx_valid(tx_valid), .tx_last(tx_last),
   .tx_class_high(tx_class_high), .tx_high_queue(tx_high_queue));

// File: verification/pte_fwd_sink.sv
`timescale 1ns/10ps
// ----------------------------------------
// Forwarding engine sink
// ----------------------------------------
module pte_fwd_sink (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [2:0] tx_valid,
   input wire pte_pkg::pte_byte_t [2:0] tx_data,
   input wire logic [2:0] tx_last,
   input wire logic [2:0] tx_class_high,
   input wire logic [2:0] tx_high_queue,
   output logic [2:0] frame_done,
   output logic [2:0][31:0] frame_sig,
   output logic [2:0] frame_cls,
   output logic [2:0] frame_hq
);
   import pte_pkg::*;
   logic [2:0][31:0] acc_reg;
   logic [2:0][31:0] acc_next;
   // Rotate and fold keeps the order of bytes without storing whole frames.
   always_comb begin
      for (int p = 0; p < 3; p++) begin
         acc_next[p] = {acc_reg[p][30:0], acc_reg[p][31]} ^ {24'h000000, tx_data[p]};
      end
   end
   // Each finished frame is filed with the class and queue the block chose.
   always_ff @(posedge ref_clk) begin
      for (int p = 0; p < 3; p++) begin
         frame_done[p] <= !rst && tx_valid[p] && tx_last[p];
         frame_sig[p] <= acc_next[p];
         frame_cls[p] <= tx_class_high[p];
         frame_hq[p] <= tx_high_queue[p];
         acc_reg[p] <= (rst || tx_last[p]) ? 32'h0 : (tx_valid[p] ? acc_next[p] : acc_reg[p]);
      end
   end
endmodule : pte_fwd_sink

// File: verification/test_port_priority_tag_editor.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_count++; \
   $display("wrong value %s expected %0h seen %0h", n, e, s); end end
// ----------------------------------------
// Bench with frame model
// ----------------------------------------
module test_port_priority_tag_editor;
   import pte_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, perr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, ecfg, es;
   logic [2:0] cen = 3'h0, dpr = 3'h0, ins = 3'h0, rem = 3'h0, spl = 3'h0;
   logic [2:0] rx_valid = 3'h0, rx_last = 3'h0, tx_valid, tx_last, tx_cls, tx_hq;
   logic [2:0] done, f_cls, f_hq;
   logic [1:0] ec;
   pte_byte_t [2:0] rx_data = '0, tx_data;
   logic [2:0][31:0] sig;
   int err_count = 0, checks_done = 0, thr = 4;
   logic [31:0] q_sig[3][$];
   logic [1:0] q_cq[3][$];
   pte_top DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_tag_class_enable(cen), .port_default_priority(dpr), .port_tag_insert_enable(ins),
      .port_tag_remove_enable(rem), .port_split_txq_select(spl), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_last(rx_last), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_last(tx_last), .tx_class_high(tx_cls), .tx_high_queue(tx_hq));
   pte_fwd_sink u_sink (.ref_clk(ref_clk), .rst(rst), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_last(tx_last), .tx_class_high(tx_cls), .tx_high_queue(tx_hq), .frame_done(done),
      .frame_sig(sig), .frame_cls(f_cls), .frame_hq(f_hq));
   // Free running system clock.
   always #20 ref_clk = ~ref_clk;
   task results;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   task automatic apb(input int wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr[0];
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      // Only the watchdog ends a wait for ready; no cycle count is assumed here.
      while (pready !== 1'b1) begin
         @(posedge ref_clk);
      end
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb
   // The model edits a copy of the frame, then the real bytes go out back to back.
   task automatic send(input int p, input bit tg, input int pr, input int len);
      pte_byte_t b[$];
      pte_byte_t o[$];
      logic [31:0] h;
      bit cls;
      h = 32'h0;
      for (int i = 0; i < 12; i++) b.push_back(8'($urandom));
      if (tg) b = {b, 8'h81, 8'h00, 8'({pr[2:0], 5'h00}), 8'h00};
      else b = {b, 8'h08, 8'h00};
      for (int i = 0; i < len; i++) b.push_back(8'($urandom));
      o = b;
      if (ins[p] && !rem[p] && !tg) o = {b[0:11], 8'h81, 8'h00, 8'({{3{dpr[p]}}, 5'h00}), 8'h00, b[12:$]};
      if (rem[p] && !ins[p] && tg) o = {b[0:11], b[16:$]};
      cls = (cen[p] && tg) ? (pr >= thr) : dpr[p];
      foreach (o[i]) h = {h[30:0], h[31]} ^ {24'h000000, o[i]};
      q_sig[p].push_back(h);
      q_cq[p].push_back({cls & spl[p], cls});
      foreach (b[i]) begin
         rx_valid[p] <= 1'b1;
         rx_data[p] <= b[i];
         rx_last[p] <= (i == b.size() - 1);
         @(posedge ref_clk);
      end
      rx_valid[p] <= 1'b0;
      rx_last[p] <= 1'b0;
      repeat (6) @(posedge ref_clk);
   endtask : send
   // Boundary priorities first, then untagged and random frames.
   task automatic run(input int p);
      for (int k = 0; k < 4; k++) begin
         send(p, k < 2 || (k == 3 && $urandom_range(0, 1)), k == 0 ? thr : (thr + 7) % 8,
            $urandom_range(20, 46));
      end
   endtask : run
   // Each finished frame is compared with the oldest one the model predicted.
   always @(posedge ref_clk) begin
      for (int p = 0; p < 3; p++) begin
         if (done[p] === 1'b1) begin
            es = q_sig[p].pop_front();
            ec = q_cq[p].pop_front();
            `CHK("frame bytes", es, sig[p])
            `CHK("frame class", ec[0], f_cls[p])
            `CHK("frame queue", ec[1], f_hq[p])
         end
      end
   end
   // Main sequence: two strap sets, each under four thresholds.
   initial begin
      void'($urandom(89450));
      for (int ph = 0; ph < 2; ph++) begin
         rst <= 1'b1;
         cen <= ph ? 3'b000 : 3'b101;
         dpr <= ph ? 3'b100 : 3'b010;
         ins <= ph ? 3'b011 : 3'b010;
         rem <= ph ? 3'b001 : 3'b100;
         spl <= ph ? 3'b110 : 3'b101;
         repeat (20) @(posedge ref_clk);
         rst <= 1'b0;
         @(posedge ref_clk);
         ecfg = 32'h0;
         for (int p = 0; p < 3; p++) ecfg[8 * p +: 5] = {spl[p], rem[p], ins[p], dpr[p], cen[p]};
         apb(0, 8'h00, 32'h0);
         `CHK("straps", ecfg, rd)
         apb(0, 8'h0C, 32'h0);
         `CHK("unmapped error", 1'b1, perr)
         `CHK("unmapped data", 32'h0, rd)
         for (int t = 0; t < 4; t++) begin
            thr = t == 0 ? 4 : (t == 1 ? 0 : (t == 2 ? 7 : $urandom_range(1, 6)));
            if (t != 0) apb(1, 8'h04, thr);
            apb(0, 8'h04, 32'h0);
            `CHK("threshold", thr, rd)
            fork
               run(0);
               run(1);
               run(2);
            join
            repeat (20) @(posedge ref_clk);
            $display("test phase %0d threshold %0d done", ph, thr);
         end
         apb(0, 8'h08, 32'h0);
         `CHK("overflow status", 32'h0, rd)
      end
      `CHK("frames missing", 0, q_sig[0].size() + q_sig[1].size() + q_sig[2].size())
      results();
   end
   // Watchdog: the run needs about 2100 cycles.
   initial begin
      #(40 * 20000);
      err_count++;
      results();
   end
endmodule : test_port_priority_tag_editor
